// ### rtl/clock_gate_pkg.sv
// Constants shared by the peripheral clock gating bank and its bench.
// Assumes byte addresses on a 32-bit register port and one system clock.
package clock_gate_pkg;

  // Register byte addresses.
  localparam logic [31:0] WORD_ONE_ADDR = 32'h4000_B00C;
  localparam logic [31:0] WORD_TWO_ADDR = 32'h4000_B010;
  localparam logic [31:0] AON_ADDR      = 32'h4000_F00C;

  // First enable word: only two gate bits live here, bits 2 and 1.
  localparam int          CORE_GATE_BIT  = 2;
  localparam int          FLASH_GATE_BIT = 1;
  localparam logic [1:0]  WORD_ONE_RESET = 2'h3;

  // Second enable word layout and reset.
  localparam int          WORD_WIDTH      = 24;
  localparam logic [23:0] WORD_TWO_RESET  = 24'hF8_783F;
  localparam int          TIMER_BUS_BIT   = 14;
  localparam int          PIN_PORT_BIT    = 13;
  localparam int          PHASE_B_BIT     = 12;
  localparam int          PHASE_A_BIT     = 11;
  localparam int          CONVERTER_BIT   = 10;
  localparam int          PULSE_LOW_BIT   = 6;
  localparam int          PULSE_COUNT     = 4;
  localparam int          FUSE_LOW_BIT    = 0;
  localparam int          FUSE_COUNT      = 6;

  // Always-on control word layout and reset.
  localparam logic [23:0] AON_RESET      = 24'h01_0000;
  localparam logic [23:0] AON_WRITE_MASK = 24'h3F_C07E;
  localparam int          SLEEP_GATE_BIT = 16;

  // Flat gate numbering: first word, then second word, then the sleep counter.
  localparam int          GATE_COUNT     = 27;
  localparam int          GATE_CORE      = 0;
  localparam int          GATE_FLASH     = 1;
  localparam int          GATE_WORD_BASE = 2;
  localparam int          GATE_SLEEP     = 26;
  localparam logic [26:0] GATE_RESET     = {AON_RESET[SLEEP_GATE_BIT], WORD_TWO_RESET, WORD_ONE_RESET};

endpackage

// ### rtl/clock_gate_cell.sv
// One glitch-free gate for a clock carried as a level sampled on clk_sys.
// Assumes the source level is synchronous to clk_sys.
module clock_gate_cell #(
  parameter logic HELD_RESET = 1'b1
) (
  // System side.
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Source clock and software enable.
  input  wire logic src_level,
  input  wire logic enable,
  // Gated clock and the enable actually in force.
  output logic      gated_level,
  output logic      enable_held
);

  // The enable is taken over only while the source is low, so no high phase is cut short.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      enable_held <= HELD_RESET;
    end else if (!src_level) begin
      enable_held <= enable;
    end
  end

  // The output follows the source while the held enable is set.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gated_level <= 1'b0;
    end else begin
      gated_level <= src_level & enable_held;
    end
  end

endmodule // clock_gate_cell

// ### rtl/peripheral_clock_gating.sv
// Register bank and gate array for the peripheral clock enables.
// Assumes a single-cycle register port on clk_sys and source clocks sampled as levels on clk_sys.
//
// Added by the designer: strobed register access.

module peripheral_clock_gating #(
  parameter int ADDR_WIDTH = 32,
  parameter int DATA_WIDTH = 32
) (
  // Clock and reset.
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // Register port.
  input  wire logic [ADDR_WIDTH-1:0] addr,
  input  wire logic [DATA_WIDTH-1:0] wr_data,
  input  wire logic                  wr_stb,
  input  wire logic                  rd_stb,
  output logic      [DATA_WIDTH-1:0] rd_data,
  // Source clocks as sampled levels, one per gate.
  input  wire logic [26:0]           clk_source,
  // Serial master clocks and their phase settings.
  input  wire logic                  serial_port_a_sck,
  input  wire logic                  serial_port_a_cpha,
  input  wire logic                  serial_port_b_sck,
  input  wire logic                  serial_port_b_cpha,
  // Gated clocks and enables in force.
  output logic      [26:0]           gated_clk,
  output logic      [26:0]           gate_held,
  // Always-on control word for the always-on domain.
  output logic      [23:0]           aon_control
);

  // Elaboration checks on the port widths.
  if (ADDR_WIDTH < 32) begin : g_addr_check
    $error("peripheral_clock_gating: ADDR_WIDTH must be at least 32");
  end
  if (DATA_WIDTH < clock_gate_pkg::WORD_WIDTH) begin : g_data_check
    $error("peripheral_clock_gating: DATA_WIDTH must be at least 24");
  end

  localparam int PHASE_A_GATE = clock_gate_pkg::GATE_WORD_BASE + clock_gate_pkg::PHASE_A_BIT;
  localparam int PHASE_B_GATE = clock_gate_pkg::GATE_WORD_BASE + clock_gate_pkg::PHASE_B_BIT;
  localparam int TIMER_GATE   = clock_gate_pkg::GATE_WORD_BASE + clock_gate_pkg::TIMER_BUS_BIT;
  localparam int PIN_GATE     = clock_gate_pkg::GATE_WORD_BASE + clock_gate_pkg::PIN_PORT_BIT;
  localparam int CONV_GATE    = clock_gate_pkg::GATE_WORD_BASE + clock_gate_pkg::CONVERTER_BIT;
  localparam int PULSE_GATE   = clock_gate_pkg::GATE_WORD_BASE + clock_gate_pkg::PULSE_LOW_BIT;
  localparam int FUSE_GATE    = clock_gate_pkg::GATE_WORD_BASE + clock_gate_pkg::FUSE_LOW_BIT;

  logic [1:0]  word_one_reg;
  logic [23:0] word_two_reg;
  logic [23:0] aon_reg;
  logic [DATA_WIDTH-1:0] rd_data_next;
  logic [26:0] gate_enable;
  logic [26:0] gate_source;
  logic        hit_one;
  logic        hit_two;
  logic        hit_aon;

  // Address decode against the full byte address.
  assign hit_one = (addr[31:0] == clock_gate_pkg::WORD_ONE_ADDR);
  assign hit_two = (addr[31:0] == clock_gate_pkg::WORD_TWO_ADDR);
  assign hit_aon = (addr[31:0] == clock_gate_pkg::AON_ADDR);

  // First enable word: bit 2 holds the core gate, bit 1 the flash gate, stored as word_one_reg bits 0 and 1.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      word_one_reg <= clock_gate_pkg::WORD_ONE_RESET;
    end else if (wr_stb && hit_one) begin
      word_one_reg[0] <= wr_data[clock_gate_pkg::CORE_GATE_BIT];
      word_one_reg[1] <= wr_data[clock_gate_pkg::FLASH_GATE_BIT];
    end
  end

  // Second enable word: every bit is stored and gates one clock.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      word_two_reg <= clock_gate_pkg::WORD_TWO_RESET;
    end else if (wr_stb && hit_two) begin
      word_two_reg <= wr_data[23:0];
    end
  end

  // Always-on word: reserved bits stay zero whatever is written.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aon_reg <= clock_gate_pkg::AON_RESET;
    end else if (wr_stb && hit_aon) begin
      aon_reg <= wr_data[23:0] & clock_gate_pkg::AON_WRITE_MASK;
    end
  end

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    rd_data_next = '0;
    if (hit_one) begin
      rd_data_next[clock_gate_pkg::CORE_GATE_BIT]  = word_one_reg[0];
      rd_data_next[clock_gate_pkg::FLASH_GATE_BIT] = word_one_reg[1];
    end else if (hit_two) begin
      rd_data_next[23:0] = word_two_reg;
    end else if (hit_aon) begin
      rd_data_next[23:0] = aon_reg;
    end
  end

  // Read data stand for the one cycle after the strobe and are zero otherwise.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (rd_stb) begin
      rd_data <= rd_data_next;
    end else begin
      rd_data <= '0;
    end
  end

  // The always-on word goes straight out to the always-on domain.
  assign aon_control = aon_reg;

  // Flat enable vector in gate order.
  assign gate_enable = {aon_reg[clock_gate_pkg::SLEEP_GATE_BIT], word_two_reg, word_one_reg};

  // Source selection: the phase gates take the serial clock, inverted by the phase setting.
  always_comb begin
    gate_source               = clk_source;
    gate_source[PHASE_A_GATE] = serial_port_a_sck ^ serial_port_a_cpha;
    gate_source[PHASE_B_GATE] = serial_port_b_sck ^ serial_port_b_cpha;
  end

  // One glitch-free gate per clock.
  for (genvar g = 0; g < clock_gate_pkg::GATE_COUNT; g++) begin : g_gate
    clock_gate_cell #(
      .HELD_RESET (clock_gate_pkg::GATE_RESET[g])
    ) u_cell (
      .clk_sys     (clk_sys),
      .rst_n       (rst_n),
      .src_level   (gate_source[g]),
      .enable      (gate_enable[g]),
      .gated_level (gated_clk[g]),
      .enable_held (gate_held[g])
    );
  end

  // Assertion helpers.
  logic [26:0] src_past;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      src_past <= '0;
    end else begin
      src_past <= gate_source;
    end
  end

  // A write to a given address, followed by the next cycle.
  sequence s_write(logic hit);
    wr_stb && hit ##1 1'b1;
  endsequence

  // A read of a given address.
  sequence s_read(logic hit);
    rd_stb && hit;
  endsequence

  // Word one bit 2 follows the written value.
  a_core_gate_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_write(hit_one) |-> word_one_reg[0] == $past(wr_data[clock_gate_pkg::CORE_GATE_BIT]))
    else $error("core gate bit did not follow the write");

  // Word one bit 1 follows the written value.
  a_flash_gate_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_write(hit_one) |-> word_one_reg[1] == $past(wr_data[clock_gate_pkg::FLASH_GATE_BIT]))
    else $error("flash gate bit did not follow the write");

  // Word two resets to its documented value.
  a_word_two_reset: assert property (@(posedge clk_sys)
    $rose(rst_n) |-> word_two_reg == clock_gate_pkg::WORD_TWO_RESET)
    else $error("word two reset value wrong");

  // A read of word two returns the stored word one cycle later.
  a_word_two_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_read(hit_two) |=> rd_data == DATA_WIDTH'($past(word_two_reg)))
    else $error("word two read data wrong");

  // A written word two value reaches the enables seen by the gates.
  a_word_two_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_write(hit_two) |-> gate_enable[25:2] == $past(wr_data[23:0]))
    else $error("word two write lost");

  // A stopped timer bus gate keeps its clock low.
  a_timer_gate_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !gate_held[TIMER_GATE] |=> !gated_clk[TIMER_GATE])
    else $error("timer bus clock ran while gated");

  // A running pin port gate passes the source through.
  a_pin_gate_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
    gate_held[PIN_GATE] |=> gated_clk[PIN_GATE] == src_past[PIN_GATE])
    else $error("pin port clock not passed while enabled");

  // The phase clock of port A is the serial clock corrected by the phase.
  a_phase_a_clock: assert property (@(posedge clk_sys) disable iff (!rst_n)
    gate_held[PHASE_A_GATE] |=> gated_clk[PHASE_A_GATE] == $past(serial_port_a_sck ^ serial_port_a_cpha))
    else $error("port A phase clock wrong");

  // The phase clock of port B is the serial clock corrected by the phase.
  a_phase_b_clock: assert property (@(posedge clk_sys) disable iff (!rst_n)
    gate_held[PHASE_B_GATE] |=> gated_clk[PHASE_B_GATE] == $past(serial_port_b_sck ^ serial_port_b_cpha))
    else $error("port B phase clock wrong");

  // The converter, pulse channels and fuse banks come out of reset as documented.
  a_gate_reset_state: assert property (@(posedge clk_sys)
    $rose(rst_n) |-> !word_two_reg[clock_gate_pkg::CONVERTER_BIT] && word_two_reg[9:6] == 4'h0
                     && word_two_reg[5:0] == 6'h3F)
    else $error("gate reset state wrong");

  // The converter clock stays low while its gate is held off.
  a_converter_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !gate_held[CONV_GATE] [*2] |-> !gated_clk[CONV_GATE])
    else $error("converter clock ran while gated");

  // The always-on word resets to its documented value.
  a_aon_reset: assert property (@(posedge clk_sys)
    $rose(rst_n) |-> aon_reg == clock_gate_pkg::AON_RESET)
    else $error("always-on reset value wrong");

  // The sleep counter enable follows a write to bit 16.
  a_sleep_gate_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_write(hit_aon) |-> gate_enable[clock_gate_pkg::GATE_SLEEP] == $past(wr_data[clock_gate_pkg::SLEEP_GATE_BIT]))
    else $error("sleep gate enable did not follow the write");

  // Reserved always-on bits read as zero.
  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_read(hit_aon) |=> (rd_data[23:0] & ~clock_gate_pkg::AON_WRITE_MASK) == 24'h00_0000)
    else $error("reserved bit read as one");

  // No gated clock falls while its source is still high.
  a_no_short_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (|(~gated_clk & $past(gated_clk) & src_past & $past(src_past))) == 1'b0)
    else $error("gated clock pulse cut short");

  // Word one comes out of reset with both gates running.
  a_word_one_reset: assert property (@(posedge clk_sys)
    $rose(rst_n) |-> word_one_reg == clock_gate_pkg::WORD_ONE_RESET)
    else $error("word one reset value wrong");

  // Word one keeps its gates between writes.
  a_word_one_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(wr_stb && hit_one) |=> $stable(word_one_reg))
    else $error("word one changed without a write");

  // A read of word one returns both gates at their own bit positions.
  a_word_one_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_read(hit_one) |=> rd_data == DATA_WIDTH'({$past(word_one_reg[0]), $past(word_one_reg[1]), 1'b0}))
    else $error("word one read data wrong");

  // Word two keeps its gates between writes.
  a_word_two_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(wr_stb && hit_two) |=> $stable(word_two_reg))
    else $error("word two changed without a write");

  // The always-on word keeps its value between writes.
  a_aon_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(wr_stb && hit_aon) |=> $stable(aon_reg))
    else $error("always-on word changed without a write");

  // A read of the always-on word returns the stored word one cycle later.
  a_aon_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_read(hit_aon) |=> rd_data == DATA_WIDTH'($past(aon_reg)))
    else $error("always-on read data wrong");

  // Only the writable always-on bits take a written value.
  a_aon_write_mask: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_write(hit_aon) |-> aon_reg == ($past(wr_data[23:0]) & clock_gate_pkg::AON_WRITE_MASK))
    else $error("always-on write mask wrong");

  // An address outside the bank reads as zero.
  a_unmapped_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rd_stb && !hit_one && !hit_two && !hit_aon |=> rd_data == '0)
    else $error("unmapped address read as nonzero");

  // A stopped core interface gate keeps its clock low.
  a_core_gate_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !gate_held[clock_gate_pkg::GATE_CORE] |=> !gated_clk[clock_gate_pkg::GATE_CORE])
    else $error("core interface clock ran while gated");

  // A stopped flash serial gate keeps its clock low.
  a_flash_gate_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !gate_held[clock_gate_pkg::GATE_FLASH] |=> !gated_clk[clock_gate_pkg::GATE_FLASH])
    else $error("flash serial clock ran while gated");

  // A running timer bus gate passes the source through.
  a_timer_gate_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
    gate_held[TIMER_GATE] |=> gated_clk[TIMER_GATE] == src_past[TIMER_GATE])
    else $error("timer bus clock not passed while enabled");

  // A stopped pin port gate keeps its clock low.
  a_pin_gate_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !gate_held[PIN_GATE] |=> !gated_clk[PIN_GATE])
    else $error("pin port clock ran while gated");

  // A stopped port A phase gate keeps its clock low.
  a_phase_a_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !gate_held[PHASE_A_GATE] |=> !gated_clk[PHASE_A_GATE])
    else $error("port A phase clock ran while gated");

  // A stopped port B phase gate keeps its clock low.
  a_phase_b_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !gate_held[PHASE_B_GATE] |=> !gated_clk[PHASE_B_GATE])
    else $error("port B phase clock ran while gated");

  // A running converter gate passes the source through.
  a_converter_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
    gate_held[CONV_GATE] |=> gated_clk[CONV_GATE] == src_past[CONV_GATE])
    else $error("converter clock not passed while enabled");

  // A stopped sleep counter gate keeps its clock low.
  a_sleep_gate_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !gate_held[clock_gate_pkg::GATE_SLEEP] |=> !gated_clk[clock_gate_pkg::GATE_SLEEP])
    else $error("sleep counter clock ran while gated");

  // Each pulse channel clock stays low while its gate is held off.
  for (genvar p = 0; p < clock_gate_pkg::PULSE_COUNT; p++) begin : g_pulse_check
    a_pulse_gate_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !gate_held[PULSE_GATE + p] |=> !gated_clk[PULSE_GATE + p])
      else $error("pulse channel clock ran while gated");
  end

  // Each running fuse bank gate passes its source through.
  for (genvar f = 0; f < clock_gate_pkg::FUSE_COUNT; f++) begin : g_fuse_check
    a_fuse_gate_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
      gate_held[FUSE_GATE + f] |=> gated_clk[FUSE_GATE + f] == src_past[FUSE_GATE + f])
      else $error("fuse bank clock not passed while enabled");
  end

  // Every gate takes its enable while the source is low and keeps it while the source is high.
  for (genvar g = 0; g < clock_gate_pkg::GATE_COUNT; g++) begin : g_held_check
    a_held_takes_enable: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !gate_source[g] |=> gate_held[g] == $past(gate_enable[g]))
      else $error("held enable missed a change while the source was low");

    a_held_waits_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
      gate_source[g] |=> $stable(gate_held[g]))
      else $error("held enable changed while the source was high");
  end

endmodule // peripheral_clock_gating

// ### bench/peripheral_clock_gating_bench.sv
// Self-checking bench for the peripheral clock gating register bank and gate array.
// Assumes the design package is compiled first and the block runs from one 25 MHz clock.
module peripheral_clock_gating_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // Clock, reset and register port.
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic [31:0] addr    = 32'h0000_0000;
  logic [31:0] wr_data = 32'h0000_0000;
  logic        wr_stb  = 1'b0;
  logic        rd_stb  = 1'b0;
  logic [31:0] rd_data;
  // Source levels, serial master clocks and phase settings.
  logic [26:0] clk_source         = '0;
  logic [26:0] src_free           = '0;
  logic [26:0] src_high           = '0;
  logic        serial_port_a_sck  = 1'b0;
  logic        serial_port_a_cpha = 1'b0;
  logic        serial_port_b_sck  = 1'b0;
  logic        serial_port_b_cpha = 1'b0;
  // Outputs and bookkeeping.
  logic [26:0] gated_clk;
  logic [26:0] gate_held;
  logic [23:0] aon_control;
  logic [31:0] rd_val;
  logic [26:0] exp_gate;
  int          err_count = 0;
  int          checked   = 0;

  // Design under test.
  peripheral_clock_gating dut_u (
    .clk_sys            (clk_sys),
    .rst_n              (rst_n),
    .addr               (addr),
    .wr_data            (wr_data),
    .wr_stb             (wr_stb),
    .rd_stb             (rd_stb),
    .rd_data            (rd_data),
    .clk_source         (clk_source),
    .serial_port_a_sck  (serial_port_a_sck),
    .serial_port_a_cpha (serial_port_a_cpha),
    .serial_port_b_sck  (serial_port_b_sck),
    .serial_port_b_cpha (serial_port_b_cpha),
    .gated_clk          (gated_clk),
    .gate_held          (gate_held),
    .aon_control        (aon_control)
  );

  // System clock of 40 ns period.
  always #20 clk_sys = ~clk_sys;

  // Source levels toggle where free running and stick high where forced.
  always @(posedge clk_sys) clk_source <= (~clk_source & src_free) | src_high;

  // Compares one value, counting every call and every mismatch.
  task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe beside address and data.
  task automatic reg_write(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr    <= a;
    wr_data <= d;
    wr_stb  <= 1'b1;
    @(posedge clk_sys);
    wr_stb  <= 1'b0;
  endtask

  // One-cycle read strobe; the data stand only in the following cycle.
  task automatic reg_read(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    @(negedge clk_sys);
    d = rd_data;
  endtask

  // Watches every gate but the phase gates 13 and 14 for eight cycles: an enabled gate must pulse, a stopped one never.
  task automatic gate_sweep(input logic [26:0] en);
    logic s;
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 27; i++) begin
      if (i != 13 && i != 14) begin
        s = 1'b0;
        repeat (8) begin
          @(negedge clk_sys);
          s = s | gated_clk[i];
        end
        check_val({31'd0, s}, {31'd0, en[i]});
      end
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("Counts: %0d comparisons, %0d mismatches", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Watchdog sized well beyond the roughly 470 cycles the tests need.
  initial begin
    repeat (4000) @(posedge clk_sys);
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    print_verdict();
  end

  // Main test sequence.
  initial begin
    repeat (3) @(posedge clk_sys);
    check_val({5'd0, gate_held}, {5'd0, clock_gate_pkg::GATE_RESET});
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    reg_read(clock_gate_pkg::WORD_ONE_ADDR, rd_val);
    check_val(rd_val, 32'h0000_0006);
    reg_read(clock_gate_pkg::WORD_TWO_ADDR, rd_val);
    check_val(rd_val, {8'h00, clock_gate_pkg::WORD_TWO_RESET});
    reg_read(clock_gate_pkg::AON_ADDR, rd_val);
    check_val(rd_val, {8'h00, clock_gate_pkg::AON_RESET});
    check_val({8'h00, aon_control}, 32'h0001_0000);
    src_free <= 27'h7FF_FFFF;
    gate_sweep(clock_gate_pkg::GATE_RESET);
    $display("Test reset values done");
    // Peripheral bits only are flipped; firmware-owned bits are written back unchanged.
    reg_read(clock_gate_pkg::WORD_TWO_ADDR, rd_val);
    reg_write(clock_gate_pkg::WORD_TWO_ADDR, rd_val ^ 32'h0000_7FFF);
    reg_write(clock_gate_pkg::WORD_ONE_ADDR, 32'h0000_0000);
    reg_read(clock_gate_pkg::AON_ADDR, rd_val);
    reg_write(clock_gate_pkg::AON_ADDR, rd_val & 32'hFFFE_FFFF);
    reg_read(clock_gate_pkg::WORD_TWO_ADDR, rd_val);
    check_val(rd_val, 32'h00F8_07C0);
    exp_gate = clock_gate_pkg::GATE_RESET ^ {1'b1, 9'h000, 15'h7FFF, 2'b11};
    gate_sweep(exp_gate);
    $display("Test gate inversion done");
    // Peripheral and reserved bits set, firmware-owned bits kept as they are, then an unmapped address.
    reg_write(clock_gate_pkg::WORD_TWO_ADDR, 32'hFFF8_7FFF);
    reg_write(clock_gate_pkg::AON_ADDR, 32'hFFC1_3F81);
    reg_write(clock_gate_pkg::WORD_ONE_ADDR, 32'hFFFF_FFFF);
    reg_write(32'h4000_B014, 32'h0000_0000);
    reg_read(clock_gate_pkg::WORD_TWO_ADDR, rd_val);
    check_val(rd_val, 32'h00F8_7FFF);
    reg_read(clock_gate_pkg::AON_ADDR, rd_val);
    check_val(rd_val, 32'h0001_0000);
    check_val({8'h00, aon_control}, 32'h0001_0000);
    reg_read(clock_gate_pkg::WORD_ONE_ADDR, rd_val);
    check_val(rd_val, 32'h0000_0006);
    reg_read(32'h4000_B014, rd_val);
    check_val(rd_val, 32'h0000_0000);
    $display("Test register access done");
    // Phase clocks follow the serial clock, inverted when the phase bit is set.
    for (int c = 0; c < 2; c++) begin
      serial_port_a_cpha <= c[0];
      serial_port_b_cpha <= c[0];
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      check_val({31'd0, gated_clk[13]}, {31'd0, c[0]});
      check_val({31'd0, gated_clk[14]}, {31'd0, c[0]});
    end
    serial_port_a_cpha <= 1'b0;
    serial_port_b_cpha <= 1'b0;
    reg_write(clock_gate_pkg::WORD_TWO_ADDR, 32'h00F8_67FF);
    // A held enable only drops at an edge with the source low, so the phase flips one edge later.
    @(posedge clk_sys);
    serial_port_a_cpha <= 1'b1;
    serial_port_b_cpha <= 1'b1;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check_val({30'd0, gated_clk[14:13]}, 32'h0000_0000);
    $display("Test phase clocks done");
    // An enable dropped while the source is high waits for the source to fall.
    src_free <= '0;
    src_high <= 27'h000_0004;
    repeat (3) @(posedge clk_sys);
    reg_write(clock_gate_pkg::WORD_TWO_ADDR, 32'h00F8_67FE);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check_val({30'd0, gate_held[2], gated_clk[2]}, 32'h0000_0003);
    src_high <= '0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check_val({30'd0, gate_held[2], gated_clk[2]}, 32'h0000_0000);
    $display("Test glitch-free switching done");
    print_verdict();
  end
endmodule // peripheral_clock_gating_bench
